// ===== rx_error_stats.sv
// receive error statistics counters with an avalon-mm register slave
`timescale 1ns/100ps
module rx_error_stats
  import rx_stat_pkg::*;
#(
  parameter int unsigned NO_BUF_WIDTH = NO_BUFFER_W,
  parameter int unsigned ERR_WIDTH    = ERR_CNT_W
) (
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire frame_report_t     frame_i,
  input  wire logic [ADDR_W-1:0] address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [31:0]       writedata_i,
  input  wire logic [3:0]        byteenable_i,
  output logic [31:0]            readdata_o,
  output logic                   waitrequest_o,
  output logic                   fcs_error_pulse_o,
  output logic                   align_error_pulse_o
);
  localparam int unsigned NUM_CNT = 5;

  logic [31:0]        net_cfg_d;
  logic [31:0]        net_cfg_q;
  logic [31:0]        readdata_d;
  logic [31:0]        readdata_q;
  logic               ack_d;
  logic               ack_q;
  logic               fcs_d;
  logic               fcs_q;
  logic               align_d;
  logic               align_q;
  logic [15:0]        max_len;
  logic               long_frame;
  logic               valid_len;
  logic               any_err;
  count_evt_t         evt;
  logic [31:0]        wmask;
  logic [31:0]        wvalue;
  logic [NUM_CNT-1:0] inc_vec;
  logic [NUM_CNT-1:0] load_vec;
  logic [31:0]        cnt_val [NUM_CNT];
  logic [NUM_CNT-1:0] cnt_sel;
  logic               cfg_sel;
  logic               unmapped;
  logic               wait_d;
  logic               wait_q;

  // length bound follows the big-frame option
  always_comb begin
    max_len    = net_cfg_q[BIG_FRAME_BIT] ? MAX_LEN_BIG : MAX_LEN_STD;
    long_frame = frame_i.length > max_len;
    valid_len  = (frame_i.length >= MIN_LEN) && !long_frame;
    any_err    = frame_i.crc_bad || frame_i.odd_bits || frame_i.symbol_err;
  end

  // classify each finished frame
  always_comb begin
    evt            = '0;
    evt.no_buffer  = frame_i.done && frame_i.no_buffer;
    evt.overrun    = frame_i.done && frame_i.dma_overrun;
    evt.symbol     = frame_i.done && frame_i.symbol_err;
    evt.overlength = frame_i.done && long_frame && !any_err;
    evt.jabber     = frame_i.done && long_frame && any_err;
    evt.fcs        = frame_i.done && valid_len && !frame_i.odd_bits
                     && (frame_i.crc_bad || frame_i.symbol_err);
    evt.align      = frame_i.done && valid_len && frame_i.odd_bits
                     && (frame_i.crc_bad || frame_i.symbol_err);
    inc_vec                 = '0;
    inc_vec[OFF_NO_BUFFER]  = evt.no_buffer;
    inc_vec[OFF_OVERRUN]    = evt.overrun;
    inc_vec[OFF_SYMBOL]     = evt.symbol;
    inc_vec[OFF_OVERLENGTH] = evt.overlength;
    inc_vec[OFF_JABBER]     = evt.jabber;
  end

  // one select line per register, unmapped words select nothing
  always_comb begin
    cnt_sel  = '0;
    cfg_sel  = 1'b0;
    unmapped = 1'b0;
    unique case (address_i)
      OFF_NO_BUFFER: begin
        cnt_sel[OFF_NO_BUFFER] = 1'b1;
      end
      OFF_OVERRUN: begin
        cnt_sel[OFF_OVERRUN] = 1'b1;
      end
      OFF_SYMBOL: begin
        cnt_sel[OFF_SYMBOL] = 1'b1;
      end
      OFF_OVERLENGTH: begin
        cnt_sel[OFF_OVERLENGTH] = 1'b1;
      end
      OFF_JABBER: begin
        cnt_sel[OFF_JABBER] = 1'b1;
      end
      OFF_NET_CFG: begin
        cfg_sel = 1'b1;
      end
      default: begin
        unmapped = 1'b1;
      end
    endcase
  end

  // byte-lane merge; a write lands at the edge that sees waitrequest low
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{byteenable_i[b]}};
    end
    load_vec = '0;
    if (write_i && ack_q) begin
      load_vec = cnt_sel;
    end
    wvalue = '0;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (cnt_sel[i]) begin
        wvalue = (cnt_val[i] & ~wmask) | (writedata_i & wmask);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      localparam int unsigned W = (g == OFF_NO_BUFFER) ? NO_BUF_WIDTH : ERR_WIDTH;
      logic [W-1:0] count;
      stat_counter #(
        .WIDTH (W)
      ) u_counter (
        .clock_i      (clock_i),
        .reset_i      (reset_i),
        .inc_i        (inc_vec[g]),
        .load_i       (load_vec[g]),
        .load_value_i (wvalue[W-1:0]),
        .count_o      (count)
      );
      assign cnt_val[g] = {{(32-W){1'b0}}, count};
    end
  endgenerate

  // bus slave: take a request, then waitrequest low for one cycle
  always_comb begin
    ack_d      = (read_i || write_i) && !ack_q;
    wait_d     = !ack_d;
    readdata_d = readdata_q;
    if (ack_d) begin
      readdata_d = '0;
      for (int i = 0; i < NUM_CNT; i++) begin
        if (cnt_sel[i]) begin
          readdata_d = cnt_val[i];
        end
      end
      if (cfg_sel) begin
        readdata_d = net_cfg_q;
      end
      if (unmapped) begin
        readdata_d = UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      readdata_q <= '0;
      ack_q      <= 1'b0;
      wait_q     <= 1'b1;
    end else begin
      readdata_q <= readdata_d;
      ack_q      <= ack_d;
      wait_q     <= wait_d;
    end
  end

  // network configuration word; only the big-frame bit acts here
  always_comb begin
    net_cfg_d = net_cfg_q;
    if (write_i && ack_q && cfg_sel) begin
      net_cfg_d = (net_cfg_q & ~wmask) | (writedata_i & wmask);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      net_cfg_q <= NET_CFG_RESET;
    end else begin
      net_cfg_q <= net_cfg_d;
    end
  end

  // pulses for the fcs and alignment counters kept outside
  always_comb begin
    fcs_d   = evt.fcs;
    align_d = evt.align;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      fcs_q   <= 1'b0;
      align_q <= 1'b0;
    end else begin
      fcs_q   <= fcs_d;
      align_q <= align_d;
    end
  end

  assign readdata_o          = readdata_q;
  assign waitrequest_o       = wait_q;
  assign fcs_error_pulse_o   = fcs_q;
  assign align_error_pulse_o = align_q;
endmodule

// ===== rx_stat_pkg.sv
// package: register map, field widths and frame length bounds for receive error counters
package rx_stat_pkg;
  localparam int unsigned ADDR_W         = 3;
  localparam logic [2:0]  OFF_NO_BUFFER  = 3'h0;
  localparam logic [2:0]  OFF_OVERRUN    = 3'h1;
  localparam logic [2:0]  OFF_SYMBOL     = 3'h2;
  localparam logic [2:0]  OFF_OVERLENGTH = 3'h3;
  localparam logic [2:0]  OFF_JABBER     = 3'h4;
  localparam logic [2:0]  OFF_NET_CFG    = 3'h5;
  localparam int unsigned BIG_FRAME_BIT  = 8;
  localparam int unsigned NO_BUFFER_W    = 16;
  localparam int unsigned ERR_CNT_W      = 8;
  localparam int unsigned LEN_W          = 16;
  localparam logic [15:0] MIN_LEN        = 16'h0040;
  localparam logic [15:0] MAX_LEN_STD    = 16'h05ee;
  localparam logic [15:0] MAX_LEN_BIG    = 16'h0600;
  localparam logic [31:0] NET_CFG_RESET  = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

  // one frame-end report from the receive path
  typedef struct packed {
    logic             done;
    logic [LEN_W-1:0] length;
    logic             crc_bad;
    logic             odd_bits;
    logic             symbol_err;
    logic             no_buffer;
    logic             dma_overrun;
  } frame_report_t;

  // per-frame increment strobes
  typedef struct packed {
    logic no_buffer;
    logic overrun;
    logic symbol;
    logic overlength;
    logic jabber;
    logic fcs;
    logic align;
  } count_evt_t;
endpackage

// ===== stat_counter.sv
// one statistics counter with software load
`timescale 1ns/100ps
module stat_counter #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             inc_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_value_i,
  output logic      [WIDTH-1:0] count_o
);
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] count_q;

  always_comb begin
    count_d = count_q;
    if (load_i) begin
      count_d = load_value_i;
    end else if (inc_i) begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_o = count_q;
endmodule

// ===== rx_error_stats_monitor.sv
// checker: bus timing and error pulse properties of the receive counters
`timescale 1ns/100ps
module rx_error_stats_monitor
  import rx_stat_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              reset_i,
  input wire frame_report_t     frame_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic              read_i,
  input wire logic              write_i,
  input wire logic [31:0]       writedata_i,
  input wire logic [3:0]        byteenable_i,
  input wire logic [31:0]       readdata_o,
  input wire logic              waitrequest_o,
  input wire logic              fcs_error_pulse_o,
  input wire logic              align_error_pulse_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_req_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("request not answered");
  a_answer_short: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("answer too long");
  a_data_holds: assert property (waitrequest_o |-> $stable(readdata_o))
    else $error("read data moved");
  a_unmapped_zero: assert property (!waitrequest_o && $past(read_i) && $past(address_i) > 3'h5
    |-> readdata_o == 32'h0) else $error("unmapped read not zero");
  a_fcs_valid: assert property (frame_i.done && frame_i.symbol_err && !frame_i.odd_bits
    && frame_i.length >= MIN_LEN && frame_i.length <= MAX_LEN_STD |=> fcs_error_pulse_o)
    else $error("fcs pulse missing");
  a_align_valid: assert property (frame_i.done && frame_i.symbol_err && frame_i.odd_bits
    && frame_i.length >= MIN_LEN && frame_i.length <= MAX_LEN_STD |=> align_error_pulse_o)
    else $error("align pulse missing");
  a_long_no_pulse: assert property (frame_i.done && frame_i.length > MAX_LEN_BIG
    |=> !fcs_error_pulse_o && !align_error_pulse_o) else $error("pulse on long frame");
  a_pulse_cause: assert property (fcs_error_pulse_o || align_error_pulse_o
    |-> $past(frame_i.done)) else $error("pulse without frame");
endmodule

bind rx_error_stats rx_error_stats_monitor mon_u (.clock_i(clock_i), .reset_i(reset_i),
  .frame_i(frame_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .fcs_error_pulse_o(fcs_error_pulse_o),
  .align_error_pulse_o(align_error_pulse_o));

// ===== rx_error_stats_tb.sv
// testbench: receive error counters over avalon-mm
`timescale 1ns/100ps
module rx_error_stats_tb;
  import rx_stat_pkg::*;
  logic              clock_i, reset_i, read_i, write_i, wait_o, fcs_o, aln_o;
  logic [ADDR_W-1:0] address_i;
  logic [3:0]        byteenable_i;
  logic [31:0]       writedata_i, readdata_o, rd;
  logic [31:0]       cnt [5];
  frame_report_t     frame_i;
  int                n_mismatch, comparisons;
  rx_error_stats dut_u (.clock_i(clock_i), .reset_i(reset_i), .frame_i(frame_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(wait_o),
    .fcs_error_pulse_o(fcs_o), .align_error_pulse_o(aln_o));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_i);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      if (wait_o === 1'b0) break;
    end
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task automatic read_all();
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, 3'(k), 32'h0);
      check(rd, cnt[k]);
    end
  endtask
  task automatic frame(input logic [15:0] len, input logic [4:0] fl, input logic [1:0] pul);
    @(posedge clock_i);
    frame_i <= {1'b1, len, fl};
    @(posedge clock_i);
    frame_i <= '0;
    #1 check({30'h0, fcs_o, aln_o}, {30'h0, pul});
  endtask
  task automatic t_reset();
    for (int k = 0; k < 5; k++) cnt[k] = 32'h0;
    read_all();
    bus(1'b0, 3'h6, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, OFF_NET_CFG, 32'h0);
    check(rd, NET_CFG_RESET);
    $display("done: reset");
  endtask
  task automatic t_load();
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 3'(k), 32'hffff_ffff);
      cnt[k] = (k == 0) ? 32'hffff : 32'hff;
    end
    bus(1'b1, 3'h7, 32'hffff_ffff);
    read_all();
    frame(16'd100, 5'b00011, 2'b00);
    cnt[0] = 32'h0;
    cnt[1] = 32'h0;
    read_all();
    $display("done: load");
  endtask
  task automatic t_frames();
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 3'(k), 32'h0);
      cnt[k] = 32'h0;
    end
    frame(16'd100, 5'b00100, 2'b10);
    frame(16'd100, 5'b01100, 2'b01);
    frame(16'd1518, 5'b10000, 2'b10);
    frame(16'd1519, 5'b00000, 2'b00);
    frame(16'd1519, 5'b00100, 2'b00);
    bus(1'b1, 3'h5, 32'h100);
    frame(16'd1536, 5'b00100, 2'b10);
    frame(16'd1536, 5'b00000, 2'b00);
    frame(16'd1537, 5'b10000, 2'b00);
    frame(16'd63, 5'b00100, 2'b00);
    frame(16'd100, 5'b00010, 2'b00);
    cnt[0] = 32'h1;
    cnt[2] = 32'h5;
    cnt[3] = 32'h1;
    cnt[4] = 32'h2;
    read_all();
    $display("done: frames");
  endtask
  task automatic t_lanes();
    byteenable_i <= 4'h2;
    bus(1'b1, OFF_NO_BUFFER, 32'h0000_ab12);
    byteenable_i <= 4'hf;
    cnt[0] = 32'h0000_ab01;
    read_all();
    bus(1'b0, OFF_NET_CFG, 32'h0);
    check(rd, 32'h0000_0100);
    $display("done: lanes");
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    reset_i = 1'b1;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = '0;
    writedata_i = '0;
    byteenable_i = 4'hf;
    frame_i = '0;
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    t_reset();
    t_load();
    t_frames();
    t_lanes();
    close_out();
  end
endmodule
